// *** hdl/dds_scoreboard.sv ***
// Destination dependency scoreboard at instruction issue, with an AHB-Lite
// register slave. Assumes the decode stage holds instr stable while
// instr_valid is high and that retire tags come from issued instructions.
//
// The implementer's own choices: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "dds_map.svh"

module dds_scoreboard #(
  parameter int NREGS = 32,  // Scoreboarded destination registers
  parameter int NTAGS = 8    // Instructions in flight
) (
  input  wire logic               ref_clk,     // Unit clock
  input  wire logic               rst_n,       // Synchronous reset, active low
  input  wire logic               ce,          // Clock enable, freezes all state
  input  wire logic               hsel,        // AHB slave select
  input  wire logic [31:0]        haddr,       // AHB address
  input  wire logic [1:0]         htrans,      // AHB transfer type
  input  wire logic               hwrite,      // AHB write
  input  wire logic [2:0]         hsize,       // AHB size, words only
  input  wire logic [31:0]        hwdata,      // AHB write data
  input  wire logic               hready,      // AHB bus ready
  output logic                    hreadyout,   // AHB slave ready
  output logic                    hresp,       // AHB response
  output logic      [31:0]        hrdata,      // AHB read data
  input  wire logic               instr_valid, // Decode offers an instruction
  input  wire dds_pkg::dds_instr_t instr,      // Offered instruction
  output logic                    instr_ready, // Instruction taken this cycle
  output logic                    iss_valid,   // One-cycle issue pulse
  output dds_pkg::dds_issue_t     iss,         // Issued instruction
  input  wire logic               ret_valid,   // Retirement pulse
  input  wire logic [`DDS_TAG_W-1:0] ret_tag   // Tag of the retiring instruction
);

  localparam int RW = $clog2(NREGS);
  localparam int TW = $clog2(NTAGS);

  typedef struct packed {
    logic [NREGS-1:0]         sb;    // Pending destination writes
    logic [NTAGS-1:0]         tv;    // Tag in flight
    logic [NTAGS-1:0]         tclr;  // Clear scoreboard on retire
    logic [NTAGS-1:0][RW-1:0] tdst;  // Destination per tag
    logic [TW-1:0]            tag;   // Next tag to hand out
    logic                     en;    // Issue enable
    logic                     aph_v; // Bus data phase pending
    logic                     aph_w;
    logic [`DDS_AOFF_HI:0]    aph_a;
    logic [31:0]              rdata;
    logic [31:0]              icnt;  // Issued instructions
    logic [31:0]              scnt;  // Cycles stalled on a hazard
    logic                     ov;
    dds_pkg::dds_issue_t      o;
  } dds_state_t;

  dds_state_t s_reg;
  dds_state_t s_next;

  logic [2:0]           grp_eighth;
  logic [`DDS_CH_W-1:0] grp_mask;
  dds_pkg::dds_dep_t    dep;
  logic                 chk;
  logic                 clr;
  logic [RW-1:0]        dst;
  logic                 hazard;
  logic                 take;

  dds_group_decode u_group (
    .exec_size            (instr.word[`DDS_ESZ_HI:`DDS_ESZ_LO]),
    .quarter_select       (instr.word[`DDS_QTR_HI:`DDS_QTR_LO]),
    .channel_group_select (instr.word[`DDS_NIB_BIT]),
    .eighth               (grp_eighth),
    .mask                 (grp_mask)
  );

  // Register read mux, snapped during the address phase
  function automatic logic [31:0] rd_word(input dds_state_t s,
                                           input logic [`DDS_AOFF_HI:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (a)
      `DDS_OFF_CTRL:
      begin
        v[`DDS_CTRL_EN] = s.en;
      end
      `DDS_OFF_SB:
      begin
        v[((NREGS < 32) ? NREGS : 32)-1:0] = s.sb[((NREGS < 32) ? NREGS : 32)-1:0];
      end
      `DDS_OFF_ICNT:
      begin
        v = s.icnt;
      end
      `DDS_OFF_SCNT:
      begin
        v = s.scnt;
      end
      default:
      begin
        v = 32'h0000_0000;
      end
    endcase
    return v;
  endfunction

  always_comb
  begin
    // Architecture-register destinations always get full protection,
    // since the control field is not honoured for them
    dep = (instr.architecture_register_space) ? dds_pkg::DDS_DEP_NORMAL
                      : dds_pkg::dds_dep_t'(instr.word[`DDS_DEP_HI:`DDS_DEP_LO]);
    chk    = ~dep[1];
    clr    = ~dep[0];
    dst    = instr.dest[RW-1:0];
    // With the check skipped no hazard stalls issue; ordering is left to software
    hazard = chk & s_reg.sb[dst];
    instr_ready = ce & s_reg.en & ~s_reg.tv[s_reg.tag] & ~hazard;
    take   = instr_valid & instr_ready;
  end

  always_comb
  begin
    s_next    = s_reg;
    s_next.ov = 1'b0;

    // Bus address phase: zero wait states, read data snapped now
    s_next.aph_v = 1'b0;
    if (hsel && htrans[1] && hready)
    begin
      s_next.aph_v = 1'b1;
      s_next.aph_w = hwrite;
      s_next.aph_a = haddr[`DDS_AOFF_HI:0];
      if (!hwrite)
      begin
        s_next.rdata = rd_word(s_reg, haddr[`DDS_AOFF_HI:0]);
      end
    end

    // Bus data phase of a write
    if (s_reg.aph_v && s_reg.aph_w)
    begin
      if (s_reg.aph_a == `DDS_OFF_CTRL)
      begin
        s_next.en = hwdata[`DDS_CTRL_EN];
      end
      if (s_reg.aph_a == `DDS_OFF_FLUSH)
      begin
        s_next.sb[((NREGS < 32) ? NREGS : 32)-1:0] =
          s_next.sb[((NREGS < 32) ? NREGS : 32)-1:0] &
          ~hwdata[((NREGS < 32) ? NREGS : 32)-1:0];
      end
    end

    // Retirement frees the tag and clears the entry unless told not to
    if (ret_valid && s_reg.tv[ret_tag[TW-1:0]])
    begin
      s_next.tv[ret_tag[TW-1:0]] = 1'b0;
      if (s_reg.tclr[ret_tag[TW-1:0]])
      begin
        s_next.sb[s_reg.tdst[ret_tag[TW-1:0]]] = 1'b0;
      end
    end

    // Issue comes last so a new pending write beats a clear of the same entry
    if (take)
    begin
      s_next.sb[dst]          = 1'b1;
      s_next.tv[s_reg.tag]    = 1'b1;
      s_next.tclr[s_reg.tag]  = clr;
      s_next.tdst[s_reg.tag]  = dst;
      s_next.tag              = s_reg.tag + TW'(1);
      s_next.icnt             = s_reg.icnt + 32'h0000_0001;
      s_next.ov               = 1'b1;
      s_next.o.tag            = '0;
      s_next.o.tag[TW-1:0]    = s_reg.tag;
      s_next.o.dest           = instr.dest;
      s_next.o.eighth         = grp_eighth;
      s_next.o.mask           = grp_mask;
      s_next.o.skip_dest_check = ~chk;
      s_next.o.skip_dest_clear = ~clr;
    end
    else if (instr_valid && hazard)
    begin
      s_next.scnt = s_reg.scnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      s_reg    <= '0;
      s_reg.en <= `DDS_CTRL_RST;
    end
    else if (ce)
    begin
      s_reg <= s_next;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = s_reg.rdata;
  assign iss_valid = s_reg.ov;
  assign iss       = s_reg.o;

endmodule
`default_nettype wire

// *** hdl/dds_map.svh ***
// Constants of the destination dependency scoreboard: field positions,
// register offsets and reset values. Definitions only; included by name.
// How it works
// - With execution size four, group select 10/1, 11/0 and 11/1 pick the 6th, 7th, 8th eighth.
// - Control 00 checks the destination scoreboard at issue and clears it at retirement.
// - Control 01 checks the destination scoreboard at issue and leaves it set at retirement.
// - With the upper control bit set the instruction issues without a scoreboard check.
// - With the lower control bit set retirement does not clear the destination entry.
// - Control 10 skips the check but still clears the entry at retirement.
// - Control 11 neither checks nor clears the entry.
`ifndef DDS_MAP_SVH
`define DDS_MAP_SVH

`define DDS_DEP_HI      11
`define DDS_DEP_LO      10
`define DDS_QTR_HI      13
`define DDS_QTR_LO      12
`define DDS_NIB_BIT     14
`define DDS_ESZ_HI      23
`define DDS_ESZ_LO      21
`define DDS_ESZ_W       3
`define DDS_ESZ_FOUR    3'h2
`define DDS_ESZ_EIGHT   3'h3
`define DDS_ESZ_SIXTEEN 3'h4

`define DDS_REG_W       8
`define DDS_TAG_W       4
`define DDS_CH_W        32

`define DDS_OFF_CTRL    8'h00
`define DDS_OFF_SB      8'h04
`define DDS_OFF_FLUSH   8'h08
`define DDS_OFF_ICNT    8'h0c
`define DDS_OFF_SCNT    8'h10
`define DDS_AOFF_HI     7

`define DDS_CTRL_EN     0
`define DDS_CTRL_RST    1'h1

`endif

// *** hdl/dds_pkg.sv ***
// Types shared by the scoreboard block, its checker, decode model and testbench.
// Assumes dds_map.svh is reachable on the include path.
`include "dds_map.svh"

package dds_pkg;

  typedef enum logic [1:0] {
    DDS_DEP_NORMAL   = 2'b00,
    DDS_DEP_NO_CLR   = 2'b01,
    DDS_DEP_NO_CHK   = 2'b10,
    DDS_DEP_NO_BOTH  = 2'b11
  } dds_dep_t;

  typedef struct packed {
    logic [31:0]            word;   // Instruction header word
    logic [`DDS_REG_W-1:0]  dest;   // Destination register index
    logic                   architecture_register_space; // Destination in architecture space
  } dds_instr_t;

  typedef struct packed {
    logic [`DDS_TAG_W-1:0]  tag;    // Retirement tag
    logic [`DDS_REG_W-1:0]  dest;   // Destination register index
    logic [2:0]             eighth; // Channel eighth for exec size four
    logic [`DDS_CH_W-1:0]   mask;   // Dispatch and vector channel mask
    logic                   skip_dest_check;
    logic                   skip_dest_clear;
  } dds_issue_t;

endpackage

// *** hdl/dds_group_decode.sv ***
// Channel-group decoder: turns execution size and group select into the
// channel mask used for dispatch and vector masks and architecture registers.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
`default_nettype none
`include "dds_map.svh"

module dds_group_decode (
  input  wire logic [`DDS_ESZ_W-1:0] exec_size,            // Encoded execution size
  input  wire logic [1:0]            quarter_select,       // Upper group select bits
  input  wire logic                  channel_group_select, // Lowest group select bit
  output logic      [2:0]            eighth,               // Selected eighth
  output logic      [`DDS_CH_W-1:0]  mask                  // Channel enable mask
);

  always_comb
  begin
    eighth = {quarter_select, channel_group_select};
    mask   = {`DDS_CH_W{1'b1}};
    unique case (exec_size)
      `DDS_ESZ_FOUR:
      begin
        // Four channels per eighth, so 10/1, 11/0, 11/1 land on lanes 20, 24, 28
        mask = 32'h0000_000f << {eighth, 2'b00};
      end
      `DDS_ESZ_EIGHT:
      begin
        mask = 32'h0000_00ff << {quarter_select, 3'b000};
      end
      `DDS_ESZ_SIXTEEN:
      begin
        mask = 32'h0000_ffff << {quarter_select[1], 4'b0000};
      end
      default:
      begin
        mask = {`DDS_CH_W{1'b1}};
      end
    endcase
  end

endmodule
`default_nettype wire

// *** bench/dds_scoreboard_checker.sv ***
// Assertion checker bound onto the scoreboard block.
// Sees top ports only; scoreboard state is inferred from issues.
`timescale 1ns/1ps
`default_nettype none
`include "dds_map.svh"
module dds_scoreboard_checker #(
  parameter int NREGS = 32, // Scoreboard entries
  parameter int NTAGS = 8   // Tags in flight
) (
  input wire logic                ref_clk,     // Unit clock
  input wire logic                rst_n,       // Reset, active low
  input wire logic                ce,          // Clock enable
  input wire logic [1:0]          htrans,      // AHB transfer type
  input wire logic                instr_valid, // Offer
  input wire dds_pkg::dds_instr_t instr,       // Offered instruction
  input wire logic                instr_ready, // Take
  input wire logic                iss_valid,   // Issue pulse
  input wire dds_pkg::dds_issue_t iss,         // Issued fields
  input wire logic                ret_valid    // Retire pulse
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic       take;
  logic       arch;
  logic       four;
  logic [2:0] grp;
  logic       pend_reg;
  logic [7:0] pend_dest_reg;
  assign take = instr_valid && instr_ready;
  assign arch = instr.architecture_register_space;
  assign four = instr.word[`DDS_ESZ_HI:`DDS_ESZ_LO] == `DDS_ESZ_FOUR;
  assign grp  = {instr.word[`DDS_QTR_HI:`DDS_QTR_LO], instr.word[`DDS_NIB_BIT]};
  // Any retire or bus access may clear the entry, so forget it then
  always_ff @(posedge ref_clk)
  begin
    pend_reg      <= rst_n && !ret_valid && !htrans[1] && (iss_valid || pend_reg);
    pend_dest_reg <= iss_valid ? iss.dest : pend_dest_reg;
  end
  issue_next_a: assert property (take |=> iss_valid)
    else $error("no issue pulse after take");
  eighth_map_a: assert property (
    take && four |=> iss.eighth == $past(grp)) else $error("wrong eighth");
  mask_map_a: assert property (
    take && four |=> iss.mask == (32'hf << {$past(grp), 2'b00})) else $error("wrong mask");
  check_flag_a: assert property (
    take && !arch |=> iss.skip_dest_check == $past(instr.word[`DDS_DEP_HI]))
    else $error("wrong check flag");
  clear_flag_a: assert property (
    take && !arch |=> iss.skip_dest_clear == $past(instr.word[`DDS_DEP_LO]))
    else $error("wrong clear flag");
  arch_normal_a: assert property (
    take && arch |=> !iss.skip_dest_check && !iss.skip_dest_clear)
    else $error("architecture destination not normal");
  hazard_hold_a: assert property (
    pend_reg && instr_valid && instr.dest == pend_dest_reg
    && (!instr.word[`DDS_DEP_HI] || arch) |-> !instr_ready)
    else $error("issued over hazard");
  freeze_ready_a: assert property (!ce |-> !instr_ready) else $error("ready while frozen");
endmodule
bind dds_scoreboard dds_scoreboard_checker #(.NREGS(NREGS), .NTAGS(NTAGS)) chk_u (
  .ref_clk, .rst_n, .ce, .htrans, .instr_valid, .instr, .instr_ready, .iss_valid, .iss,
  .ret_valid);
`default_nettype wire

// *** bench/dds_decode_model.sv ***
// Decode-stage model: offers one instruction and holds it until taken.
// Assumes instr_ready is sampled on the rising edge of ref_clk.
`timescale 1ns/1ps
`default_nettype none
module dds_decode_model (
  input  wire logic                ref_clk,     // Unit clock
  input  wire logic                instr_ready, // Scoreboard takes
  output var  logic                instr_valid, // Offer pending
  output var  dds_pkg::dds_instr_t instr        // Offered instruction
);
  initial
  begin
    instr_valid = 1'b0;
    instr       = '1;
  end
  // Caller orders hazards itself; idle header is inverted, never stale
  task automatic send(input logic [31:0] w, input logic [7:0] d, input logic a);
    instr_valid <= 1'b1;
    instr       <= {w, d, a};
    do @(posedge ref_clk); while (instr_ready !== 1'b1);
    instr_valid <= 1'b0;
    instr       <= ~instr;
  endtask
endmodule
`default_nettype wire

// *** bench/dds_scoreboard_tb.sv ***
// Testbench of the scoreboard block: AHB tasks, decode model, issue/retire tests.
// Needs the checker file compiled alongside for its bind.
`timescale 1ns/1ps
`default_nettype none
`include "dds_map.svh"
module dds_scoreboard_tb;
  logic                ref_clk = 1'b0;
  logic                rst_n, ce, hready, hwrite, ret_valid, hreadyout, hresp;
  logic [1:0]          htrans;
  logic [31:0]         haddr, hwdata, hrdata;
  logic [3:0]          ret_tag, t1, t2;
  logic                instr_valid, instr_ready, iss_valid;
  dds_pkg::dds_instr_t instr;
  dds_pkg::dds_issue_t iss;
  int                  err_count = 0, checks_done = 0, iss_count = 0;
  always #4 ref_clk = ~ref_clk;
  assign hready = hreadyout;
  dds_decode_model dec_u (.ref_clk, .instr_ready, .instr_valid, .instr);
  dds_scoreboard dut_u (.ref_clk, .rst_n, .ce, .hsel(1'b1), .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready, .hreadyout, .hresp, .hrdata, .instr_valid, .instr,
    .instr_ready, .iss_valid, .iss, .ret_valid, .ret_tag);
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Write stores d; read compares against d
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    haddr  <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge ref_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hready !== 1'b1);
    check({31'h0, hresp}, 32'h0);
    if (!w)
      check(hrdata, d);
  endtask
  task automatic issue(input logic [1:0] c, input logic [2:0] g, input logic [7:0] d,
                       input logic a, output logic [3:0] t);
    dec_u.send({8'h0, `DDS_ESZ_FOUR, 6'h0, g[0], g[2:1], c, 10'h0}, d, a);
    // Pulse stands for the cycle after the take; look at it on the edge that ends it
    @(posedge ref_clk);
    check({31'h0, iss_valid}, 32'h1);
    check({24'h0, iss.dest}, {24'h0, d});
    check({28'h0, iss.tag}, 32'(iss_count % 8));
    iss_count++;
    check({29'h0, iss.eighth}, {29'h0, g});
    check(iss.mask, 32'hf << {g, 2'b00});
    check({30'h0, iss.skip_dest_check, iss.skip_dest_clear}, {30'h0, a ? 2'b00 : c});
    t = iss.tag;
  endtask
  task automatic retire(input logic [3:0] t);
    ret_valid <= 1'b1;
    ret_tag   <= t;
    @(posedge ref_clk);
    ret_valid <= 1'b0;
    @(posedge ref_clk);
  endtask
  initial
  begin
    #200000;
    err_count++;
    end_sim();
  end
  initial
  begin
    {rst_n, hwrite, ret_valid, htrans, haddr, hwdata, ret_tag} <= '0;
    ce <= 1'b1;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    bus(1'b0, `DDS_OFF_CTRL, 32'h1);
    bus(1'b0, `DDS_OFF_SB, 32'h0);
    bus(1'b0, 8'h20, 32'h0);
    $display("test reset done");
    for (int k = 0; k < 2; k++)
    begin
      if (k == 0)
        ce <= 1'b0;
      else
        bus(1'b1, `DDS_OFF_CTRL, 32'h0);
      fork
        issue(2'b00, 3'h0, 8'h9, 1'b0, t1);
        begin
          #2 check({31'h0, instr_ready}, 32'h0);
          repeat (3) @(posedge ref_clk);
          if (k == 0)
            ce <= 1'b1;
          else
            bus(1'b1, `DDS_OFF_CTRL, 32'h1);
        end
      join
      retire(t1);
    end
    $display("test hold done");
    for (int g = 0; g < 8; g++)
    begin
      issue(2'b11, g[2:0], 8'(g + 16), 1'b0, t1);
      retire(t1);
    end
    bus(1'b0, `DDS_OFF_SB, 32'h00ff0000);
    bus(1'b1, `DDS_OFF_FLUSH, 32'h00ff0000);
    $display("test groups done");
    for (int c = 0; c < 4; c++)
    begin
      issue(c[1:0], 3'h0, 8'h1, 1'b0, t1);
      fork
        issue(c[1:0], 3'h0, 8'h1, 1'b0, t2);
        begin
          #2 check({31'h0, instr_ready}, {31'h0, c[1]});
          if (!c[1])
          begin
            repeat (3) @(posedge ref_clk);
            check({31'h0, instr_ready}, 32'h0);
            if (c[0])
              bus(1'b1, `DDS_OFF_FLUSH, 32'h2);
            else
              retire(t1);
          end
        end
      join
      if (c != 0)
        retire(t1);
      retire(t2);
      bus(1'b0, `DDS_OFF_SB, {30'h0, c[0], 1'b0});
      bus(1'b1, `DDS_OFF_FLUSH, 32'h2);
    end
    issue(2'b11, 3'h0, 8'h3, 1'b1, t1);
    retire(t1);
    bus(1'b0, `DDS_OFF_SB, 32'h0);
    bus(1'b0, `DDS_OFF_ICNT, 32'(iss_count));
    bus(1'b0, `DDS_OFF_SCNT, 32'h9);
    $display("test controls done");
    end_sim();
  end
endmodule
`default_nettype wire
